// File: common/wdt_defines.vh
// constants for the watchdog timer unit
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH
`define WDT_CTRL_ADDR     8'hC0
`define WDT_CTRL_RESET    8'h10
`define WDT_PRE_MSB       7
`define WDT_PRE_LSB       4
`define WDT_IRQ_SEL_BIT   3
`define WDT_FLAG_BIT      2
`define WDT_ENABLE_BIT    1
`define WDT_UNLOCK_BIT    0
`define WDT_CLK_HZ        40000000
`define WDT_TB_HZ         32768
`define WDT_CNT_W         16
`define WDT_PRE_IMMEDIATE 4'h8
// timebase ticks for the 15.6 ms base timeout: 2^9
`define WDT_BASE_TICKS    16'h0200
`endif

// File: logic/wdt_unit.v
// watchdog timer unit with protected control register
`timescale 1ns/1ps
`include "wdt_defines.vh"
module wdt_unit #(
  parameter CLK_HZ = `WDT_CLK_HZ,
  parameter TB_HZ  = `WDT_TB_HZ
) (
  input  wire       clock,
  input  wire       sys_rst,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_wr,
  input  wire       sfr_bit_wr,
  input  wire [2:0] sfr_bit_sel,
  input  wire       sfr_bit_val,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  output reg        wd_reset_req,
  output reg        wd_irq
);
  // fractional accumulator gives an average 32.768 kHz enable from the 40 MHz clock
  reg [31:0] tb_acc_q;
  reg        tb_tick_q;
  reg [15:0] wd_count_q;
  reg  [3:0] wd_prescale_q;
  reg        wd_irq_select_q;
  reg        wd_timeout_flag_q;
  reg        wd_enable_q;
  reg        wd_write_unlock_q;
  wire [7:0] watchdog_control;
  wire       hit;
  wire       bit_hit;
  wire       any_wr;
  wire [7:0] wr_val;
  wire       unlock_only;
  wire       accept;
  wire [15:0] limit;
  wire       timeout;
  wire       pre_valid;
  wire       immediate;

  function [15:0] wdt_limit;
    input [3:0] pre;
    begin
      wdt_limit = `WDT_BASE_TICKS << pre[2:0];
    end
  endfunction

  assign watchdog_control = {wd_prescale_q, wd_irq_select_q, wd_timeout_flag_q,
                             wd_enable_q, wd_write_unlock_q};
  assign hit     = (sfr_addr == `WDT_CTRL_ADDR);
  assign bit_hit = hit && sfr_bit_wr;
  assign any_wr  = hit && (sfr_wr || sfr_bit_wr);
  // bit-addressed writes modify one bit of the current image
  assign wr_val  = sfr_bit_wr ?
                   ((watchdog_control & ~(8'h01 << sfr_bit_sel)) |
                    ({7'h00, sfr_bit_val} << sfr_bit_sel)) : sfr_wdata;
  assign unlock_only = any_wr && bit_hit && (sfr_bit_sel == 3'h0) && sfr_bit_val;
  // any write other than the unlock itself must directly follow the unlock
  assign accept    = any_wr && !unlock_only && wd_write_unlock_q;
  assign pre_valid = !wd_prescale_q[3];
  assign immediate = (wd_prescale_q == `WDT_PRE_IMMEDIATE);
  assign limit     = wdt_limit(wd_prescale_q);
  assign timeout   = wd_enable_q && pre_valid && tb_tick_q &&
                     (wd_count_q == limit - 16'h0001);

  always @(posedge clock) begin
    if (sys_rst) begin
      tb_acc_q  <= 32'h00000000;
      tb_tick_q <= 1'b0;
    end else if (tb_acc_q + TB_HZ >= CLK_HZ) begin
      tb_acc_q  <= tb_acc_q + TB_HZ - CLK_HZ;
      tb_tick_q <= 1'b1;
    end else begin
      tb_acc_q  <= tb_acc_q + TB_HZ;
      tb_tick_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      wd_count_q <= 16'h0000;
    end else if (!wd_enable_q || accept) begin
      // stopped while disabled; any accepted write re-arms
      wd_count_q <= 16'h0000;
    end else if (timeout) begin
      wd_count_q <= 16'h0000;
    end else if (tb_tick_q) begin
      wd_count_q <= wd_count_q + 16'h0001;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      {wd_prescale_q, wd_irq_select_q, wd_timeout_flag_q, wd_enable_q,
       wd_write_unlock_q} <= `WDT_CTRL_RESET;
      wd_reset_req <= 1'b0;
      wd_irq       <= 1'b0;
    end else begin
      wd_reset_req <= 1'b0;
      wd_irq       <= 1'b0;
      wd_write_unlock_q <= unlock_only;
      if (accept) begin
        wd_prescale_q   <= wr_val[`WDT_PRE_MSB:`WDT_PRE_LSB];
        wd_irq_select_q <= wr_val[`WDT_IRQ_SEL_BIT];
        wd_enable_q     <= wr_val[`WDT_ENABLE_BIT];
        wd_timeout_flag_q <= wr_val[`WDT_FLAG_BIT];
      end
      if (timeout) begin
        wd_timeout_flag_q <= 1'b1;
        if (wd_irq_select_q) begin
          wd_irq <= 1'b1;
        end else begin
          wd_reset_req <= 1'b1;
          wd_enable_q  <= 1'b0;
        end
      end else if (wd_enable_q && immediate) begin
        wd_timeout_flag_q <= 1'b1;
        wd_reset_req      <= 1'b1;
        wd_enable_q       <= 1'b0;
      end
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && hit) begin
      sfr_rdata <= watchdog_control;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end
endmodule // wdt_unit

// File: tb/wdt_unit_monitor.sv
// port assertions for the watchdog unit
`timescale 1ns/1ps
module wdt_mon (
  input wire logic clock, sys_rst, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, wd_reset_req, wd_irq,
  input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
  input wire logic [2:0] sfr_bit_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [15:0] gap_q;
  // saturates so a long idle stretch never wraps back under the bound
  always @(posedge clock) gap_q <= (sys_rst | wd_irq | sfr_bit_wr) ? 16'h0 : gap_q + (gap_q != 16'hFFFF);
  sequence s_unl_wr;
    sfr_bit_wr && sfr_bit_sel == 3'h0 && sfr_bit_val ##1 sfr_wr && sfr_addr == 8'hC0;
  endsequence
  a_one_source: assert property (!(wd_irq && wd_reset_req)) else $error("both");
  a_irq_pulse: assert property (wd_irq |=> !wd_irq) else $error("irq long");
  a_rst_pulse: assert property (wd_reset_req |=> !wd_reset_req) else $error("rst long");
  a_rdata_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00) else $error("rdata");
  a_irq_not_early: assert property (wd_irq |-> gap_q > 16'h07D0) else $error("early");
  a_immediate_rst: assert property (s_unl_wr ##0 sfr_wdata[7:4] == 4'h8 && sfr_wdata[1]
    |-> ##[1:3] wd_reset_req) else $error("no reset");
  a_off_quiet: assert property (s_unl_wr ##0 !sfr_wdata[1]
    |=> (!wd_reset_req && !wd_irq) [*8]) else $error("fired");
  a_flag_irq: assert property (wd_irq && sfr_rd ##1 sfr_rd |=> sfr_rdata[2]) else $error("flag");
  a_rst_clears: assert property (wd_reset_req && sfr_rd ##1 sfr_rd
    |=> sfr_rdata[2:1] == 2'b10) else $error("enable");
endmodule // wdt_mon
bind wdt_unit wdt_mon u_mon (.clock, .sys_rst, .sfr_wr, .sfr_bit_wr, .sfr_bit_val, .sfr_rd,
  .wd_reset_req, .wd_irq, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_bit_sel);

// File: tb/wdt_unit_tb_top.sv
// self-checking bench for the watchdog unit
`timescale 1ns/1ps
module wdt_unit_tb_top;
  logic clock = 0, sys_rst = 1, sfr_wr = 0, sfr_bit_wr = 0, sfr_bit_val = 0, sfr_rd = 1;
  logic [7:0] sfr_addr = 8'hC0, sfr_wdata = 8'h00, sfr_rdata, v;
  logic [2:0] sfr_bit_sel = 3'h0;
  logic wd_reset_req, wd_irq;
  logic [1:0] s;
  int mismatches = 0, n_tests = 0, cyc = 0;
  // quarter-rate timebase keeps the 512-tick base timeout near 2048 cycles
  wdt_unit #(.TB_HZ(32'h0098_9680)) u_dut (.clock, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .sfr_rd, .sfr_rdata, .wd_reset_req, .wd_irq);
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) if (++cyc == 32'h9C40) begin mismatches++; stop_test; end
  task automatic stop_test;
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin mismatches++; $display("wrong value %0t: %h not %h", $time, got, exp); end
  endtask
  // m: 0 no unlock, 1 unlock just before, 2 unlock with a gap cycle
  task automatic wrc(input logic [7:0] d, input int m);
    if (m > 0) begin sfr_bit_wr <= 1; sfr_bit_val <= 1; @(posedge clock); sfr_bit_wr <= 0; end
    if (m > 1) @(posedge clock);
    sfr_wr <= 1; sfr_wdata <= d; @(posedge clock); sfr_wr <= 0; repeat (2) @(posedge clock);
  endtask
  task automatic wt(output logic [1:0] r);
    r = 2'b00;
    repeat (5000) begin
      @(posedge clock);
      if (wd_irq | wd_reset_req) begin r = {wd_reset_req, wd_irq}; break; end
    end
    repeat (2) @(posedge clock);
  endtask
  initial begin
    v = $urandom(32'h11cae2a6);
    repeat (8) @(posedge clock);
    sys_rst <= 0; repeat (3) @(posedge clock);
    chk(sfr_rdata, 8'h10);
    // read strobe low: read data must fall back to zero
    sfr_rd <= 0; repeat (2) @(posedge clock); chk(sfr_rdata, 8'h00);
    sfr_rd <= 1; repeat (2) @(posedge clock);
    wrc(8'hF2, 0); chk(sfr_rdata, 8'h10);
    repeat (6) begin
      v = $urandom & 8'hFD; // enable off so nothing fires
      wrc(v, 1); chk(sfr_rdata, v & 8'hFC);
    end
    wrc(8'h00, 2); chk(sfr_rdata, v & 8'hFC);
    wrc(8'h0A, 1); wt(s); chk({6'h0, s}, 8'h01);
    chk(sfr_rdata, 8'h0E);
    wt(s); chk({6'h0, s}, 8'h01);
    wrc(8'h08, 1); wt(s); chk({6'h0, s}, 8'h00);
    wrc(8'h12, 1); wt(s); chk({6'h0, s}, 8'h02);
    chk(sfr_rdata, 8'h14);
    // immediate code fires during the write task, so only the image is left to read
    wrc(8'h82, 1); @(posedge clock); chk(sfr_rdata, 8'h84);
    stop_test;
  end
endmodule // wdt_unit_tb_top
